// ===== hdl/epf_fetch_bus.sv
// Purpose: Program fetch steering and external memory bus sequencer
// Assumes: Core presents one request at a time and holds it until done
// Notes: Port pins split into in/out/enable; the bench resolves wires
`timescale 1ns/10ps
`default_nettype none
module epf_fetch_bus #(
  parameter logic [1:0] ROM_SIZE = epf_pkg::ROM_4K
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic externalAccessStrap,
  input wire logic fetchReq,
  input wire logic [15:0] fetchAddr,
  input wire logic vectorReq,
  input wire logic [2:0] vectorIndex,
  input wire logic dataReadReq,
  input wire logic dataWriteReq,
  input wire logic dataWide,
  input wire logic [7:0] dataAddrLow,
  input wire logic [15:0] dataPointerReg,
  input wire logic [7:0] dataWriteValue,
  input wire logic [7:0] romData,
  output logic [15:0] romAddr,
  output logic romRead,
  output logic [15:0] fetchPc,
  output logic [7:0] fetchData,
  output logic [7:0] dataReadValue,
  output logic done,
  output logic busy,
  input wire logic [7:0] muxedAddrDataPortIn,
  output logic [7:0] muxedAddrDataPortOut,
  output logic muxedAddrDataPortOe,
  output logic [7:0] upperAddrPortOut,
  output logic upperAddrPortOe,
  output logic addrLatchStrobe,
  output logic programReadStrobeN,
  output logic dataReadStrobeN,
  output logic dataStoreStrobeN
);

  // ****************************************
  // Address selection
  // ****************************************
  logic [15:0] pc;
  logic [15:0] nextPc;
  logic pcValid;
  logic [15:0] firstExternal;
  logic goExternal;
  logic anyFetch;
  logic [15:0] reqAddr;

  always_comb begin
    unique case (ROM_SIZE)
      epf_pkg::ROM_4K: firstExternal = epf_pkg::FIRST_EXT_4K;
      epf_pkg::ROM_8K: firstExternal = epf_pkg::FIRST_EXT_8K;
      epf_pkg::ROM_16K: firstExternal = epf_pkg::FIRST_EXT_16K;
      epf_pkg::ROM_32K: firstExternal = epf_pkg::FIRST_EXT_32K;
    endcase
  end

  always_comb begin
    if (vectorReq) begin
      nextPc = epf_pkg::VECTOR_BASE + ({13'h0000, vectorIndex} << epf_pkg::VECTOR_SPACING_SHIFT);
    end else if (!pcValid) begin
      nextPc = epf_pkg::RESET_VECTOR;
    end else begin
      nextPc = fetchAddr;
    end
  end

  assign anyFetch = fetchReq || vectorReq;
  assign goExternal = !externalAccessStrap || (nextPc >= firstExternal);

  // Data cycles carry their own address; the fetch counter is left alone
  always_comb begin
    if (anyFetch) begin
      reqAddr = nextPc;
    end else if (dataWide) begin
      reqAddr = dataPointerReg;
    end else begin
      reqAddr = {8'h00, dataAddrLow};
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  epf_pkg::epf_state_t state;
  epf_pkg::epf_kind_t kind;
  logic extCycle;
  logic phaseLoad;
  logic [2:0] phaseLength;
  logic phaseDone;
  logic dataCycle;
  logic [7:0] storeByte;

  epf_phase_counter phaseTimer (
    .clk(clk),
    .rstn(rstn),
    .load(phaseLoad),
    .length(phaseLength),
    .done(phaseDone)
  );

  always_comb begin
    phaseLoad = 1'b0;
    phaseLength = epf_pkg::ADDR_CYCLES;
    unique case (state)
      epf_pkg::ST_IDLE: begin
        phaseLoad = extCycle;
        phaseLength = epf_pkg::ADDR_CYCLES;
      end
      epf_pkg::ST_ADDR: begin
        phaseLoad = phaseDone;
        phaseLength = epf_pkg::LATCH_CYCLES;
      end
      epf_pkg::ST_HOLD: begin
        phaseLoad = phaseDone;
        phaseLength = epf_pkg::STROBE_CYCLES;
      end
      epf_pkg::ST_STROBE: phaseLoad = 1'b0;
      epf_pkg::ST_DONE: phaseLoad = 1'b0;
      default: phaseLoad = 1'b0;
    endcase
  end

  // Internal fetches take one cycle; data requests always go off chip
  // Fetch outranks data, so no strobe rides on an internal fetch
  assign dataCycle = !anyFetch && (dataReadReq || dataWriteReq);
  assign extCycle = (anyFetch && goExternal) || dataCycle;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state <= epf_pkg::ST_IDLE;
    end else begin
      unique case (state)
        epf_pkg::ST_IDLE: begin
          if (extCycle) begin
            state <= epf_pkg::ST_ADDR;
          end
        end
        epf_pkg::ST_ADDR: begin
          if (phaseDone) begin
            state <= epf_pkg::ST_HOLD;
          end
        end
        epf_pkg::ST_HOLD: begin
          if (phaseDone) begin
            state <= epf_pkg::ST_STROBE;
          end
        end
        epf_pkg::ST_STROBE: begin
          if (phaseDone) begin
            state <= epf_pkg::ST_DONE;
          end
        end
        epf_pkg::ST_DONE: state <= epf_pkg::ST_IDLE;
        default: state <= epf_pkg::ST_IDLE;
      endcase
    end
  end

  // Capture the request so the core may not change it mid-cycle
  always_ff @(posedge clk) begin
    if (!rstn) begin
      kind <= epf_pkg::KIND_CODE;
      storeByte <= 8'h00;
    end else if (state == epf_pkg::ST_IDLE && extCycle) begin
      storeByte <= dataWriteValue;
      if (anyFetch) begin
        kind <= epf_pkg::KIND_CODE;
      end else begin
        kind <= dataReadReq ? epf_pkg::KIND_DREAD : epf_pkg::KIND_DWRITE;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      pc <= epf_pkg::RESET_VECTOR;
      pcValid <= 1'b0;
    end else if (anyFetch && state == epf_pkg::ST_IDLE) begin
      pc <= nextPc;
      pcValid <= 1'b1;
    end
  end
  assign fetchPc = pc;

  // ****************************************
  // Internal ROM port
  // ****************************************
  assign romAddr = nextPc;
  assign romRead = anyFetch && !goExternal && state == epf_pkg::ST_IDLE;

  // ****************************************
  // Pin drive
  // ****************************************
  logic startCycle;
  logic strobePhase;
  logic lastStrobe;
  logic codeCycle;

  assign startCycle = phaseLoad && (state == epf_pkg::ST_IDLE);
  assign strobePhase = (state == epf_pkg::ST_STROBE);
  assign lastStrobe = strobePhase && phaseDone;
  assign codeCycle = (kind == epf_pkg::KIND_CODE);

  // Multiplexed port: address first, then store data or float
  always_ff @(posedge clk) begin
    if (!rstn) begin
      muxedAddrDataPortOut <= 8'h00;
      muxedAddrDataPortOe <= 1'b0;
    end else if (startCycle) begin
      muxedAddrDataPortOut <= reqAddr[7:0];
      muxedAddrDataPortOe <= 1'b1;
    end else if (state == epf_pkg::ST_HOLD && phaseDone) begin
      if (kind == epf_pkg::KIND_DWRITE) begin
        muxedAddrDataPortOut <= storeByte;
      end else begin
        muxedAddrDataPortOe <= 1'b0;
      end
    end else if (lastStrobe) begin
      muxedAddrDataPortOe <= 1'b0;
    end
  end

  // Upper port holds the high byte for the whole cycle
  always_ff @(posedge clk) begin
    if (!rstn) begin
      upperAddrPortOut <= 8'h00;
      upperAddrPortOe <= 1'b0;
    end else if (startCycle) begin
      upperAddrPortOut <= reqAddr[15:8];
      upperAddrPortOe <= 1'b1;
    end else if (lastStrobe) begin
      upperAddrPortOe <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      addrLatchStrobe <= 1'b0;
    end else if (startCycle) begin
      addrLatchStrobe <= 1'b1;
    end else if (state == epf_pkg::ST_ADDR && phaseDone) begin
      // Low byte stays valid for a cycle after the strobe falls
      addrLatchStrobe <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      programReadStrobeN <= 1'b1;
      dataReadStrobeN <= 1'b1;
      dataStoreStrobeN <= 1'b1;
    end else if (state == epf_pkg::ST_HOLD && phaseDone) begin
      programReadStrobeN <= !codeCycle;
      dataReadStrobeN <= !(kind == epf_pkg::KIND_DREAD);
      dataStoreStrobeN <= !(kind == epf_pkg::KIND_DWRITE);
    end else if (lastStrobe) begin
      programReadStrobeN <= 1'b1;
      dataReadStrobeN <= 1'b1;
      dataStoreStrobeN <= 1'b1;
    end
  end

  // ****************************************
  // Result capture
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rstn) begin
      fetchData <= 8'h00;
      dataReadValue <= 8'h00;
      done <= 1'b0;
    end else begin
      done <= romRead || lastStrobe;
      if (romRead) begin
        fetchData <= romData;
      end else if (lastStrobe && codeCycle) begin
        fetchData <= muxedAddrDataPortIn;
      end else if (lastStrobe && kind == epf_pkg::KIND_DREAD) begin
        dataReadValue <= muxedAddrDataPortIn;
      end
    end
  end

  assign busy = (state != epf_pkg::ST_IDLE);

endmodule
`default_nettype wire

// ===== hdl/epf_phase_counter.sv
// Purpose: Down counter timing one bus phase
// Assumes: Single clock, synchronous active-low reset
// Notes: done is high in the last cycle of the loaded phase
`timescale 1ns/10ps
`default_nettype none
module epf_phase_counter (
  input wire logic clk,
  input wire logic rstn,
  input wire logic load,
  input wire logic [2:0] length,
  output logic done
);

  logic [2:0] count;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      count <= 3'h0;
    end else if (load) begin
      count <= length - 3'h1;
    end else if (count != 3'h0) begin
      count <= count - 3'h1;
    end
  end

  assign done = (count == 3'h0);

endmodule
`default_nettype wire

// ===== hdl/epf_pkg.sv
// Purpose: Constants for the program fetch steering and external bus sequencer
// Assumes: 20 MHz clock, synchronous active-low reset
// Notes: Boundaries, vectors and bus phase lengths live here
package epf_pkg;

  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam logic [15:0] VECTOR_BASE = 16'h0003;
  localparam int VECTOR_SPACING_SHIFT = 3;

  // On-chip ROM size codes
  localparam logic [1:0] ROM_4K = 2'h0;
  localparam logic [1:0] ROM_8K = 2'h1;
  localparam logic [1:0] ROM_16K = 2'h2;
  localparam logic [1:0] ROM_32K = 2'h3;

  localparam logic [15:0] FIRST_EXT_4K = 16'h1000;
  localparam logic [15:0] FIRST_EXT_8K = 16'h2000;
  localparam logic [15:0] FIRST_EXT_16K = 16'h4000;
  localparam logic [15:0] FIRST_EXT_32K = 16'h8000;

  // Cycles per bus phase
  localparam logic [2:0] ADDR_CYCLES = 3'h2;
  localparam logic [2:0] LATCH_CYCLES = 3'h1;
  localparam logic [2:0] STROBE_CYCLES = 3'h3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_HOLD = 3'b010,
    ST_STROBE = 3'b011,
    ST_DONE = 3'b100
  } epf_state_t;

  typedef enum logic [1:0] {
    KIND_CODE = 2'b00,
    KIND_DREAD = 2'b01,
    KIND_DWRITE = 2'b10
  } epf_kind_t;

endpackage

// ===== verification/epf_ext_mem.sv
// Purpose: External program and data memory with address latch
// Assumes: Code and data bytes derive from the latched address
// Notes: Released bus toggles so stale data never passes
`timescale 1ns/10ps
`default_nettype none
module epf_ext_mem (
  input wire logic clk,
  input wire logic [7:0] lowOut,
  input wire logic [7:0] highOut,
  input wire logic ale,
  input wire logic progRdN,
  input wire logic dataRdN,
  input wire logic storeN,
  output logic [7:0] drive,
  output logic [15:0] wrAddr,
  output logic [7:0] wrData
);
  logic [7:0] latchLow = 8'h00;
  logic [7:0] last = 8'h00;
  wire logic [15:0] addr = {highOut, latchLow};
  // Shared memory: one read strobe for both spaces
  wire logic rdN = progRdN & dataRdN;
  always_ff @(posedge clk) if (ale) latchLow <= lowOut;
  assign drive = !rdN ? addr[7:0] ^ addr[15:8] ^ 8'h5A : ~last;
  always_ff @(posedge clk) last <= drive;
  always_ff @(posedge clk) begin
    if (!storeN) begin
      wrAddr <= addr;
      wrData <= lowOut;
    end
  end
endmodule
`default_nettype wire

// ===== verification/epf_fetch_bus_properties.sv
// Purpose: Bus timing checks for the fetch sequencer
// Assumes: Single clock, synchronous active-low reset
// Notes: Bound into every instance of the sequencer
`timescale 1ns/10ps
`default_nettype none
module epf_fetch_bus_properties #(parameter logic [1:0] ROM_SIZE = 2'h0) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic externalAccessStrap,
  input wire logic romRead,
  input wire logic [15:0] romAddr,
  input wire logic done,
  input wire logic muxedAddrDataPortOe,
  input wire logic upperAddrPortOe,
  input wire logic addrLatchStrobe,
  input wire logic programReadStrobeN,
  input wire logic dataReadStrobeN,
  input wire logic dataStoreStrobeN
);
  localparam logic [15:0] LIM = 16'h1000 << ROM_SIZE;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_progStrobeLen; $fell(programReadStrobeN) |-> !programReadStrobeN [*3] ##1 programReadStrobeN; endproperty
  a_progStrobeLen: assert property (p_progStrobeLen) else $error("read strobe length");
  property p_bound; romRead |-> externalAccessStrap && romAddr < LIM; endproperty
  a_bound: assert property (p_bound) else $error("internal fetch out of range");
  property p_float; !programReadStrobeN |-> !muxedAddrDataPortOe && upperAddrPortOe; endproperty
  a_float: assert property (p_float) else $error("port not floated");
  property p_ale;
    $rose(addrLatchStrobe) |-> muxedAddrDataPortOe && upperAddrPortOe ##1 addrLatchStrobe
      ##1 !addrLatchStrobe && muxedAddrDataPortOe;
  endproperty
  a_ale: assert property (p_ale) else $error("latch strobe timing");
  property p_order;
    $rose(addrLatchStrobe) |-> ##3 ($fell(programReadStrobeN) || $fell(dataReadStrobeN) || $fell(dataStoreStrobeN));
  endproperty
  a_order: assert property (p_order) else $error("strobe after address late");
  property p_done; $rose(programReadStrobeN) || $rose(dataReadStrobeN) |-> done && !upperAddrPortOe; endproperty
  a_done: assert property (p_done) else $error("no answer after strobe");
  property p_int; romRead |=> done && programReadStrobeN; endproperty
  a_int: assert property (p_int) else $error("internal fetch answer");
  property p_excl; $onehot0({!programReadStrobeN, !dataReadStrobeN, !dataStoreStrobeN}); endproperty
  a_excl: assert property (p_excl) else $error("strobes overlap");
  property p_store; !dataStoreStrobeN |-> muxedAddrDataPortOe && upperAddrPortOe; endproperty
  a_store: assert property (p_store) else $error("store without bus");
  c_ext: cover property ($fell(programReadStrobeN));
  c_wr: cover property ($fell(dataStoreStrobeN));
  c_int: cover property (romRead);
endmodule
bind epf_fetch_bus epf_fetch_bus_properties #(.ROM_SIZE(ROM_SIZE)) u_props (.clk(clk), .rstn(rstn),
  .externalAccessStrap(externalAccessStrap), .romRead(romRead), .romAddr(romAddr), .done(done),
  .muxedAddrDataPortOe(muxedAddrDataPortOe), .upperAddrPortOe(upperAddrPortOe),
  .addrLatchStrobe(addrLatchStrobe), .programReadStrobeN(programReadStrobeN),
  .dataReadStrobeN(dataReadStrobeN), .dataStoreStrobeN(dataStoreStrobeN));
`default_nettype wire

// ===== verification/testbench.sv
// Purpose: Self-checking bench for the fetch sequencer
// Assumes: 8K on-chip ROM variant
// Notes: Fixed seed keeps random runs repeatable
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic strap = 1'b1;
  logic fReq = 1'b0, vReq = 1'b0, rReq = 1'b0, wReq = 1'b0, wide = 1'b0, sawProgStrobe = 1'b0;
  logic sawBusy = 1'b0;
  logic [2:0] vIdx = 3'h0;
  logic [7:0] aLow = 8'h00, wVal = 8'h00;
  logic [15:0] fAddr = 16'h0000, dataPtr = 16'h0000, r;
  wire logic [15:0] romAddr, fetchPc, wrAddr;
  wire logic [7:0] romData, fetchData, rdVal, pIn, pOut, hiOut, hiPin, drv, wrData;
  wire logic romRead, done, busy, pOe, hiOe, ale, progStrobeN, rdN, wrN;
  int miscompares = 0, tests_run = 0, seed = 1087, i;
  logic [15:0] corner [4] = '{16'h1FFF, 16'h2000, 16'hFFFF, 16'h0000};
  assign romData = romAddr[7:0] + romAddr[15:8];
  assign pIn = pOe ? pOut : drv;
  // Released upper pins read inverted so a stale address shows
  assign hiPin = hiOe ? hiOut : ~hiOut;
  epf_fetch_bus #(.ROM_SIZE(epf_pkg::ROM_8K)) dut (.clk(clk), .rstn(rstn), .externalAccessStrap(strap),
    .fetchReq(fReq), .fetchAddr(fAddr), .vectorReq(vReq), .vectorIndex(vIdx), .dataReadReq(rReq),
    .dataWriteReq(wReq), .dataWide(wide), .dataAddrLow(aLow), .dataPointerReg(dataPtr),
    .dataWriteValue(wVal), .romData(romData), .romAddr(romAddr), .romRead(romRead), .fetchPc(fetchPc),
    .fetchData(fetchData), .dataReadValue(rdVal), .done(done), .busy(busy), .muxedAddrDataPortIn(pIn),
    .muxedAddrDataPortOut(pOut), .muxedAddrDataPortOe(pOe), .upperAddrPortOut(hiOut),
    .upperAddrPortOe(hiOe), .addrLatchStrobe(ale), .programReadStrobeN(progStrobeN),
    .dataReadStrobeN(rdN), .dataStoreStrobeN(wrN));
  epf_ext_mem mem (.clk(clk), .lowOut(pIn), .highOut(hiPin), .ale(ale), .progRdN(progStrobeN),
    .dataRdN(rdN), .storeN(wrN), .drive(drv), .wrAddr(wrAddr), .wrData(wrData));
  initial forever #25 clk = ~clk;
  always @(posedge clk) if (progStrobeN === 1'b0) sawProgStrobe = 1'b1;
  // ****
  // Helpers
  // ****
  function automatic logic isExt(input logic [15:0] a);
    return !strap || a >= epf_pkg::FIRST_EXT_8K;
  endfunction
  function automatic logic [7:0] expByte(input logic [15:0] a, input logic ext);
    return ext ? a[7:0] ^ a[15:8] ^ 8'h5A : a[7:0] + a[15:8];
  endfunction
  task automatic stop_test;
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic go(input int k, input logic [15:0] a);
    int n;
    @(posedge clk);
    #1;
    sawProgStrobe = 1'b0;
    fAddr = a;
    dataPtr = a;
    aLow = a[7:0];
    vIdx = a[2:0];
    wVal = a[15:8];
    // Kind 4 raises a fetch and a data read together
    {fReq, vReq, rReq, wReq} = {k == 0 || k == 4, k == 1, k == 2 || k == 4, k == 3};
    n = 0;
    // Wait past one edge first so a stale answer is not taken
    do begin
      @(posedge clk);
      #1;
      n++;
      if (n == 1) sawBusy = busy;
    end while (done !== 1'b1 && n < 20);
    if (n >= 20) begin
      miscompares++;
      stop_test();
    end
    {fReq, vReq, rReq, wReq} = 4'h0;
  endtask
  task automatic fetchCheck(input int k, input logic [15:0] a, input logic [15:0] pc);
    go(k, a);
    chk(fetchPc, pc);
    chk(16'(fetchData), 16'(expByte(pc, isExt(pc))));
    chk(16'(sawProgStrobe), 16'(isExt(pc)));
    chk(16'(sawBusy), 16'(isExt(pc)));
  endtask
  task automatic dataCheck(input int k, input logic [15:0] a, input logic w);
    logic [15:0] expAddr;
    wide = w;
    expAddr = w ? a : {8'h00, a[7:0]};
    go(k, a);
    chk(16'(sawProgStrobe), 16'h0000);
    chk(16'(sawBusy), 16'h0001);
    if (k == 2) chk(16'(rdVal), 16'(expByte(expAddr, 1'b1)));
    else chk(wrAddr, expAddr);
    if (k == 3) chk(16'(wrData), 16'(a[15:8]));
  endtask
  // ****
  // Sequence
  // ****
  initial begin
    repeat (8) @(posedge clk);
    #1 rstn = 1'b1;
    fetchCheck(0, 16'h1234, 16'h0000);
    $display("reset fetch done");
    for (i = 0; i < 4; i++) fetchCheck(0, corner[i], corner[i]);
    for (i = 0; i < 8; i++) fetchCheck(1, 16'(i), 16'(3 + 8 * i));
    fetchCheck(4, 16'h0123, 16'h0123);
    $display("boundary and vectors done");
    strap = 1'b0;
    fetchCheck(0, 16'h0000, 16'h0000);
    for (i = 0; i < 30; i++) begin
      r = 16'($random(seed));
      strap = 1'($random(seed));
      fetchCheck(0, r, r);
    end
    $display("random fetches done");
    rstn = 1'b0;
    repeat (2) @(posedge clk);
    #1 rstn = 1'b1;
    fetchCheck(0, 16'h1234, 16'h0000);
    $display("second reset done");
    for (i = 0; i < 8; i++) dataCheck(2 + i % 2, 16'($random(seed)), 1'(i / 2 % 2));
    $display("data accesses done");
    stop_test();
  end
endmodule
`default_nettype wire
